// >>> lcs_block.sv
// logic array block: ten logic cells with carry-select chain and apb
`timescale 1ns/1ns
`default_nettype none
module lcs_block #(
  parameter int NCELL = 10,  // cells per block
  parameter int HALF  = 5    // rail regeneration point
) (
  input  wire logic              CLOCK,          // 250 MHz clock
  input  wire logic              RESET_N,        // async reset, low
  input  wire logic              PSEL,           // apb select
  input  wire logic              PENABLE,        // apb access phase
  input  wire logic              PWRITE,         // apb direction
  input  wire logic [7:0]        PADDR,          // apb byte address
  input  wire logic [31:0]       PWDATA,         // apb write data
  output logic      [31:0]       PRDATA,         // apb read data
  output logic                   PREADY,         // apb ready
  output logic                   PSLVERR,        // unmapped address
  input  wire logic [NCELL-1:0]  DATA_A,         // first data input
  input  wire logic [NCELL-1:0]  DATA_B,         // second data input
  input  wire logic [NCELL-1:0]  DATA_C,         // third data input
  input  wire logic [NCELL-1:0]  DATA_D,         // fourth data input
  input  wire logic [1:0]        ACLR,           // two async clears
  input  wire logic              ALOAD,          // async preset/load
  input  wire logic              SCLR,           // block sync clear
  input  wire logic              SLOAD,          // block sync load
  input  wire logic [1:0]        CLK_ENA,        // two clock enables
  input  wire logic              SUB,            // high: subtract
  input  wire logic              CARRY_IN,       // from left block
  input  wire logic              LUT_CHAIN_IN,   // from block above
  input  wire logic              REG_CHAIN_IN,   // from block above
  input  wire logic              CLR_PIN_I,      // clear pin level
  output logic                   CLR_PIN_O,      // pin as i/o, level
  output logic                   CLR_PIN_OE,     // pin as i/o, drive
  output logic      [NCELL-1:0]  REG_OUT,        // registered outputs
  output logic      [NCELL-1:0]  COMB_OUT,       // table outputs
  output logic                   CARRY_OUT,      // to right block
  output logic                   LUT_CHAIN_OUT,  // last table output
  output logic                   REG_CHAIN_OUT   // last register
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [lcs_pkg::CTRL_W-1:0] ctrl;
    logic [NCELL-1:0]           pwr;
    logic [29:0]                sel;
    logic [NCELL-1:0][15:0]     lut;
    logic [NCELL-1:0]           q;
    logic [NCELL-1:0]           comb;
    logic                       cout;
    logic                       lco;
    logic [2:0]                 sync;
    logic                       pin;
    logic                       pin_o;
    logic                       pin_oe;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
  } lcs_state_t;

  lcs_state_t r;
  lcs_state_t n;

  // lut window decode, shared by read and write
  function automatic logic lut_hit(input logic [7:0] a);
    lut_hit = (a[7:6] == lcs_pkg::OFS_LUT[7:6]) && (a[1:0] == 2'h0)
              && (a[5:2] < 4'(NCELL));
  endfunction

  logic           clr_act;   // chip-wide clear in force
  logic           apb_wr;    // write completes this edge
  logic [3:0]     start;     // first cell of the chain
  logic           arith;
  logic [NCELL:0] sumv;      // helper for checks
  assign clr_act = r.ctrl[lcs_pkg::CTRL_CLR_EN] & ~r.pin;
  assign apb_wr  = PSEL & PENABLE & PWRITE & r.pready;
  assign start   = r.ctrl[lcs_pkg::CTRL_START +: 4];
  assign arith   = r.ctrl[lcs_pkg::CTRL_ARITH];
  assign sumv    = {1'b0, DATA_A} + {1'b0, DATA_B};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic z, o, blk, ch, pq, b, s, c, d, ena, ac, in_ch;
    z     = 1'b0;
    o     = 1'b1;
    blk   = 1'b0;
    ch    = LUT_CHAIN_IN;
    pq    = REG_CHAIN_IN;
    b     = 1'b0;
    s     = 1'b0;
    c     = 1'b0;
    d     = 1'b0;
    ena   = 1'b0;
    ac    = 1'b0;
    in_ch = 1'b0;
    n     = r;
    n.ctrl[lcs_pkg::CTRL_INIT] = 1'b0;  // one-cycle strobe
    // pin sampler: change taken once the last two stages agree
    n.sync = {r.sync[1:0], CLR_PIN_I};
    if (r.sync[1] == r.sync[2]) begin
      n.pin = r.sync[2];
    end
    // pin as ordinary i/o while the clear function is off
    n.pin_o  = r.ctrl[lcs_pkg::CTRL_GP_OUT];
    n.pin_oe = r.ctrl[lcs_pkg::CTRL_GP_OE] & ~r.ctrl[lcs_pkg::CTRL_CLR_EN];
    // cell walk, lowest bit first
    for (int i = 0; i < NCELL; i++) begin
      in_ch = arith && (4'(i) >= start);
      if (in_ch && 4'(i) == start) begin
        z   = 1'b0;
        o   = 1'b1;
        // carry-in from left block or from add/subtract at first cell
        if (start == 4'h0 && r.ctrl[lcs_pkg::CTRL_CONT]) begin
          blk = CARRY_IN;
        end else begin
          blk = SUB;
        end
      end else if (in_ch && i == HALF) begin
        // second group: chosen rail becomes new block carry
        blk = blk ? o : z;
        z   = 1'b0;
        o   = 1'b1;
      end
      b = DATA_B[i] ^ SUB;
      if (!DATA_D[i]) begin
        b = ~b;  // local count-down control
      end
      // sum is a^b when the chosen rail carries zero, its inverse when it carries one
      s = (blk ? o : z) ? ~(DATA_A[i] ^ b) : (DATA_A[i] ^ b);
      z = z ? (DATA_A[i] | b) : (DATA_A[i] & b);
      o = o ? (DATA_A[i] | b) : (DATA_A[i] & b);
      // normal mode table, third input optionally from the chain
      d = r.ctrl[lcs_pkg::CTRL_LUTCH] ? ch : DATA_C[i];
      c = r.lut[i][{DATA_D[i], d, DATA_B[i], DATA_A[i]}];
      if (in_ch) begin
        c = s;
      end
      ch          = c;
      n.comb[i]   = c;
      d           = r.ctrl[lcs_pkg::CTRL_REGCH] ? pq : c;
      pq          = r.q[i];
      ena = CLK_ENA[r.sel[lcs_pkg::SEL_ENA + i]];
      if (in_ch) begin
        ena = ena & DATA_C[i];
      end
      ac = ACLR[r.sel[lcs_pkg::SEL_ACLR + i]];
      // register priorities, strongest first
      if (clr_act) begin
        n.q[i] = 1'b0;
      end else if (ac) begin
        n.q[i] = 1'b0;
      end else if (ALOAD) begin
        n.q[i] = r.sel[lcs_pkg::SEL_PRE + i] ? 1'b1 : DATA_D[i];
      end else if (r.ctrl[lcs_pkg::CTRL_INIT]) begin
        n.q[i] = r.pwr[i];
      end else if (ena) begin
        if (SCLR) begin
          n.q[i] = 1'b0;
        end else if (SLOAD) begin
          n.q[i] = DATA_C[i];
        end else begin
          n.q[i] = d;
        end
      end
    end
    n.cout = blk ? o : z;
    n.lco  = ch;
    // apb: answer one cycle into the access phase
    n.pready  = PSEL & PENABLE & ~r.pready;
    n.pslverr = 1'b0;
    if (PSEL & PENABLE & ~r.pready) begin
      n.prdata  = 32'h00000000;
      n.pslverr = 1'b0;
      unique case (PADDR)
        lcs_pkg::OFS_CTRL:    n.prdata[lcs_pkg::CTRL_W-1:0] = r.ctrl;
        lcs_pkg::OFS_POWERUP: n.prdata[NCELL-1:0] = r.pwr;
        lcs_pkg::OFS_SELECT:  n.prdata[29:0] = r.sel;
        lcs_pkg::OFS_STATUS: begin
          n.prdata[NCELL-1:0]       = r.q;
          n.prdata[lcs_pkg::ST_COUT] = r.cout;
          n.prdata[lcs_pkg::ST_PIN]  = r.pin;
          n.prdata[lcs_pkg::ST_CLR]  = clr_act;
        end
        lcs_pkg::OFS_COMB:    n.prdata[NCELL-1:0] = r.comb;
        default: begin
          if (lut_hit(PADDR)) begin
            n.prdata[15:0] = r.lut[PADDR[5:2]];
          end else begin
            n.pslverr = 1'b1;
          end
        end
      endcase
    end
    if (apb_wr) begin
      unique case (PADDR)
        lcs_pkg::OFS_CTRL:    n.ctrl = PWDATA[lcs_pkg::CTRL_W-1:0];
        lcs_pkg::OFS_POWERUP: n.pwr  = PWDATA[NCELL-1:0];
        lcs_pkg::OFS_SELECT:  n.sel  = PWDATA[29:0];
        default: begin
          if (lut_hit(PADDR)) begin
            n.lut[PADDR[5:2]] = PWDATA[15:0];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register; cell registers power up low
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      r         <= '0;
      r.ctrl    <= lcs_pkg::CTRL_RST;
      r.pwr     <= lcs_pkg::PWR_RST;
      r.sel     <= lcs_pkg::SEL_RST;
      r.lut     <= {NCELL{lcs_pkg::LUT_RST}};
      r.sync    <= lcs_pkg::SYNC_RST;
    end else begin
      r <= n;
    end
  end

  // outputs straight from state
  assign PRDATA        = r.prdata;
  assign PREADY        = r.pready;
  assign PSLVERR       = r.pslverr;
  assign CLR_PIN_O     = r.pin_o;
  assign CLR_PIN_OE    = r.pin_oe;
  assign REG_OUT       = r.q;
  assign COMB_OUT      = r.comb;
  assign CARRY_OUT     = r.cout;
  assign LUT_CHAIN_OUT = r.lco;
  assign REG_CHAIN_OUT = r.q[NCELL-1];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  AST_CHIP_CLEAR: assert property (clr_act |=> REG_OUT == '0)
    else $error("chip-wide clear left a register set");
  AST_CLEAR_HOLD: assert property (
    r.ctrl[lcs_pkg::CTRL_CLR_EN] && !r.pin && (r.sync[2:1] == 2'b00) && !apb_wr
    |=> clr_act ##1 (REG_OUT == '0))
    else $error("clear released while pin held low");
  AST_ACLR_WINS: assert property (
    !clr_act && ALOAD && ACLR[r.sel[lcs_pkg::SEL_ACLR]] |=> !REG_OUT[0])
    else $error("async load beat async clear");
  AST_PRESET_ONE: assert property (
    !clr_act && ALOAD && !(|ACLR) && r.sel[lcs_pkg::SEL_PRE + NCELL - 1]
    |=> REG_OUT[NCELL-1])
    else $error("preset did not load one");
  AST_ALOAD_DATA: assert property (
    !clr_act && ALOAD && !(|ACLR) && !r.sel[lcs_pkg::SEL_PRE]
    |=> REG_OUT[0] == $past(DATA_D[0]))
    else $error("async load data not from fourth input");
  AST_ADD: assert property (
    arith && start == 4'h0 && !r.ctrl[lcs_pkg::CTRL_CONT] && !SUB
    && (&DATA_D) |=> {CARRY_OUT, COMB_OUT} == $past(sumv))
    else $error("carry-select sum wrong");
  AST_SUB: assert property (
    arith && start == 4'h0 && !r.ctrl[lcs_pkg::CTRL_CONT] && SUB && (&DATA_D)
    |=> COMB_OUT == NCELL'($past(DATA_A) - $past(DATA_B)))
    else $error("subtraction wrong");
  AST_SYNC_CLEAR: assert property (
    !clr_act && !(|ACLR) && !ALOAD && !r.ctrl[lcs_pkg::CTRL_INIT] && SCLR
    && (&CLK_ENA) && !arith |=> REG_OUT == '0)
    else $error("sync clear missed a register");
  AST_APB_READY: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle");

  COV_ADD: cover property (arith && start == 4'h0 ##1 CARRY_OUT);
  COV_PRESET: cover property (ALOAD && r.sel[lcs_pkg::SEL_PRE + NCELL - 1] ##1 REG_OUT[NCELL-1]);
  COV_PIN_CLEAR: cover property (clr_act ##1 !clr_act);

endmodule : lcs_block
`default_nettype wire

// >>> lcs_block_tb.sv
// self-checking bench for the logic array block
`timescale 1ns/1ns
`default_nettype none
module lcs_block_tb;
  logic        clk, rst_n, psel, pen, pwr, prdy, perr, aload, sclr, sload, sub;
  logic [7:0]  paddr;
  logic [31:0] pwd, prd, q;
  logic [9:0]  da, db, dc, dd, ro, co;
  logic [1:0]  aclr, ena;
  logic        cin, lin, rin, pin, po, poe, cout, lout, rout;
  logic        cin_w, lut_w, reg_w, drv, lvl;
  logic [10:0] e;
  logic [15:0] m = 16'hcafe;
  logic [20:0] ta[4] = '{{1'b0, 10'h3ff, 10'h001}, {1'b0, 10'h155, 10'h2aa},
                         {1'b1, 10'h200, 10'h201}, {1'b1, 10'h123, 10'h123}};
  int          n_mismatch, check_count;

  lcs_block lcs_block_i (
    .CLOCK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .DATA_A(da), .DATA_B(db), .DATA_C(dc), .DATA_D(dd), .ACLR(aclr), .ALOAD(aload),
    .SCLR(sclr), .SLOAD(sload), .CLK_ENA(ena), .SUB(sub), .CARRY_IN(cin),
    .LUT_CHAIN_IN(lin), .REG_CHAIN_IN(rin), .CLR_PIN_I(pin), .CLR_PIN_O(po),
    .CLR_PIN_OE(poe), .REG_OUT(ro), .COMB_OUT(co), .CARRY_OUT(cout),
    .LUT_CHAIN_OUT(lout), .REG_CHAIN_OUT(rout));
  lcs_nbr lcs_nbr_i (.cin_w(cin_w), .lut_w(lut_w), .reg_w(reg_w), .drv(drv), .lvl(lvl),
    .pin_o(po), .pin_oe(poe), .cin(cin), .lut(lin), .rg(rin), .pin(pin));

  // ----------------------------------------
  // clock, compares and bus tasks
  // ----------------------------------------
  // 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic chkb(input string nm, input logic x, input logic g);
    chk(nm, {31'h0, x}, {31'h0, g});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one apb transfer; only the watchdog ends a wait on a dead slave
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    q = prd;
    chkb("pready", 1'b1, prdy);
    chkb("pslverr", er, perr);
    psel <= 1'b0;
    pen <= 1'b0;
    // idle edge so a following call never re-raises psel in this step
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 1'b0);
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    {psel, pen, pwr, paddr, pwd, sclr, sload, sub, aclr, da, db, dc} = '0;
    {cin_w, lut_w, reg_w, lvl} = '0;
    {dd, ena, aload, drv} = '1;
    rst_n = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    tick(5);
    rst_n <= 1'b1;
    acc(1'b0, lcs_pkg::OFS_CTRL, 32'h0, 1'b0);
    chk("ctrl", {20'h0, lcs_pkg::CTRL_RST}, q);
    acc(1'b1, 8'h30, 32'h1, 1'b1);
    acc(1'b0, 8'h30, 32'h0, 1'b1);
    chk("unmapped read", 32'h0, q);
    tick(3);
    chk("reg_out", 32'h0, 32'(ro));
    acc(1'b0, lcs_pkg::OFS_STATUS, 32'h0, 1'b0);
    chkb("clear active", 1'b1, q[12]);
    // board lets go of the clear; async load then takes the fourth input
    lvl <= 1'b1;
    tick(6);
    chk("reg_out", 32'h3ff, 32'(ro));
    dd <= 10'h2a5;
    tick(2);
    chk("reg_out", 32'h2a5, 32'(ro));
    wr(lcs_pkg::OFS_SELECT, 32'h3e00_0000);
    tick(2);
    chk("reg_out", 32'h3e5, 32'(ro));
    aclr <= 2'b01;
    tick(2);
    chk("reg_out", 32'h0, 32'(ro));
    aclr <= 2'b10;
    wr(lcs_pkg::OFS_SELECT, 32'h3e00_03e0);
    tick(2);
    chk("reg_out", 32'h005, 32'(ro));
    {aclr, aload} <= 3'h0;
    wr(lcs_pkg::OFS_SELECT, 32'h0);
    // shared synchronous controls, clear over load
    sload <= 1'b1;
    dc <= 10'h155;
    tick(2);
    chk("reg_out", 32'h155, 32'(ro));
    sclr <= 1'b1;
    tick(2);
    chk("reg_out", 32'h0, 32'(ro));
    // cells 0..4 follow the second clock enable, which is held off
    wr(lcs_pkg::OFS_SELECT, 32'h0000_7c00);
    {sclr, ena} <= 3'h1;
    tick(2);
    chk("reg_out", 32'h140, 32'(ro));
    wr(lcs_pkg::OFS_SELECT, 32'h0);
    {sclr, sload, ena} <= 4'h0;
    wr(lcs_pkg::OFS_POWERUP, 32'h0f0);
    wr(lcs_pkg::OFS_CTRL, 32'h802);
    tick(3);
    chk("reg_out", 32'h0f0, 32'(ro));
    ena <= 2'h3;
    // every table address in normal mode
    for (int k = 0; k < 10; k++) begin
      wr(lcs_pkg::OFS_LUT + 8'(4 * k), {16'h0, m});
    end
    for (int i = 0; i < 16; i++) begin
      {dd, dc, db, da} <= {{10{i[3]}}, {10{i[2]}}, {10{i[1]}}, {10{i[0]}}};
      tick(2);
      chk("comb_out", {22'h0, {10{m[i]}}}, 32'(co));
    end
    for (int k = 0; k < 10; k++) begin
      wr(lcs_pkg::OFS_LUT + 8'(4 * k), 32'hf0f0);
    end
    wr(lcs_pkg::OFS_CTRL, 32'h006);
    for (int v = 0; v < 2; v++) begin
      lut_w <= v[0];
      tick(2);
      chk("comb_out", v[0] ? 32'h3ff : 32'h0, 32'(co));
      chkb("lut_chain_out", v[0], lout);
    end
    // register chain fills one cell per edge
    wr(lcs_pkg::OFS_CTRL, 32'h00a);
    sclr <= 1'b1;
    tick(1);
    sclr <= 1'b0;
    reg_w <= 1'b1;
    tick(1);
    for (int k = 1; k <= 10; k++) begin
      tick(1);
      chk("reg_out", (32'h1 << k) - 32'h1, 32'(ro));
    end
    chkb("reg_chain_out", 1'b1, rout);
    // arithmetic: add and subtract, whole block
    reg_w <= 1'b0;
    wr(lcs_pkg::OFS_CTRL, 32'h003);
    foreach (ta[i]) begin
      {sub, da, db} <= ta[i];
      e = {1'b0, ta[i][19:10]} + {1'b0, ta[i][9:0] ^ {10{ta[i][20]}}} + 11'(ta[i][20]);
      tick(2);
      chk("sum", 32'(e), {21'h0, cout, co});
      chk("reg_out", 32'(e[9:0]), 32'(ro));
    end
    // local counter enable low holds the registers; low fourth input inverts b
    {sub, da, db, dc, dd} <= {1'b0, 10'h155, 10'h0aa, 10'h000, 10'h000};
    tick(2);
    chk("sum", 32'h4aa, {21'h0, cout, co});
    chk("reg_out", 32'h0, 32'(ro));
    {dc, dd} <= {10'h3ff, 10'h3ff};
    wr(lcs_pkg::OFS_CTRL, 32'h053);
    {sub, da, db} <= {1'b0, 10'h3ff, 10'h020};
    tick(2);
    chk("upper sum", 32'h20, {26'h0, cout, co[9:5]});
    wr(lcs_pkg::OFS_CTRL, 32'h103);
    cin_w <= 1'b1;
    {da, db} <= {10'h3ff, 10'h000};
    tick(2);
    chk("chained sum", 32'h400, {21'h0, cout, co});
    // clear pin: override while enabled, plain output otherwise
    wr(lcs_pkg::OFS_CTRL, 32'h602);
    {lvl, sload, dc} <= {1'b0, 1'b1, 10'h3ff};
    tick(7);
    chkb("pin drive", 1'b0, poe);
    chk("reg_out", 32'h0, 32'(ro));
    drv <= 1'b0;
    wr(lcs_pkg::OFS_CTRL, 32'h400);
    tick(6);
    chkb("pin drive", 1'b1, poe);
    chkb("pin level", 1'b0, po);
    chk("reg_out", 32'h3ff, 32'(ro));
    report_and_stop();
  end
  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    tick(20000);
    n_mismatch++;
    report_and_stop();
  end
endmodule  // lcs_block_tb
`default_nettype wire

// >>> lcs_nbr.sv
// far-side model: upper block chains, left block carry, board on the clear pin
`timescale 1ns/1ns
`default_nettype none
module lcs_nbr (
  input  wire logic cin_w,   // carry out of the left block
  input  wire logic lut_w,   // table output of the cell above
  input  wire logic reg_w,   // register output of the cell above
  input  wire logic drv,     // board drives the pin
  input  wire logic lvl,     // board pin level
  input  wire logic pin_o,   // block pin level
  input  wire logic pin_oe,  // block pin drive
  output logic      cin,     // carry into the block
  output logic      lut,     // lut chain into cell 0
  output logic      rg,      // register chain into cell 0
  output logic      pin      // resolved pin level
);
  // ----------------------------------------
  // neighbours and pin
  // ----------------------------------------
  // chains come straight from the neighbouring cells
  assign cin = cin_w;
  assign lut = lut_w;
  assign rg  = reg_w;
  // pull-up wins when nobody drives; a board holding it low keeps clears on
  assign pin = pin_oe ? pin_o : (drv ? lvl : 1'b1);
endmodule  // lcs_nbr
`default_nettype wire

// >>> lcs_pkg.sv
// constants shared by the logic array block and its register map
package lcs_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_POWERUP = 8'h04;
  localparam logic [7:0] OFS_SELECT  = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_COMB    = 8'h10;
  localparam logic [7:0] OFS_LUT     = 8'h40;  // mask k at OFS_LUT + 4*k
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_ARITH  = 0;   // dynamic arithmetic mode
  localparam int CTRL_CLR_EN = 1;   // pin acts as chip-wide clear
  localparam int CTRL_LUTCH  = 2;   // lut chain feeds third table input
  localparam int CTRL_REGCH  = 3;   // register chain feeds register
  localparam int CTRL_START  = 4;   // 4-bit chain start cell
  localparam int CTRL_CONT   = 8;   // chain continues from left block
  localparam int CTRL_GP_OUT = 9;   // pin level as plain i/o
  localparam int CTRL_GP_OE  = 10;  // pin drive as plain i/o
  localparam int CTRL_INIT   = 11;  // self-clearing power-up load
  localparam int CTRL_W      = 12;
  localparam logic [11:0] CTRL_RST = 12'h002;
  // ----------------------------------------------------------------
  // select register fields, one bit per cell each
  // ----------------------------------------------------------------
  localparam int SEL_ACLR = 0;     // which of two async clears
  localparam int SEL_ENA  = 10;    // which of two clock enables
  localparam int SEL_PRE  = 20;    // async load drives a one
  // ----------------------------------------------------------------
  // status register fields and reset values
  // ----------------------------------------------------------------
  localparam int ST_COUT = 10;
  localparam int ST_PIN  = 11;
  localparam int ST_CLR  = 12;
  localparam logic [9:0]  PWR_RST  = 10'h000;
  localparam logic [29:0] SEL_RST  = 30'h00000000;
  localparam logic [15:0] LUT_RST  = 16'h0000;
  localparam logic [2:0]  SYNC_RST = 3'h0;  // starts low: clear holds until pin seen high
endpackage : lcs_pkg
